// [logic/uswc_pkg.sv]
// Purpose: Shared constants and carriers for the USB suspend/wakeup control block
// Assumes: Single 40 MHz clock, asynchronous active-high reset
// Notes: Register offsets are byte addresses on the plain register port
package uswc_pkg;

  localparam int USWC_PINS = 11;
  localparam int USWC_ADDR_W = 8;
  localparam int USWC_DATA_W = 32;
  localparam int USWC_SYNC_STAGES = 2;

  // Register offsets
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_WAKE_SEL = 8'h00;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_WAKE_MATCH = 8'h04;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_SUSP_LEVEL = 8'h08;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_SUSP_OD = 8'h0C;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_STATUS = 8'h10;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_IRQ_STAT = 8'h14;
  localparam logic [USWC_ADDR_W-1:0] USWC_OFS_IRQ_MASK = 8'h18;

  // Reset values of the configuration registers
  localparam logic [USWC_PINS-1:0] USWC_RST_WAKE_SEL = 11'h000;
  localparam logic [USWC_PINS-1:0] USWC_RST_WAKE_MATCH = 11'h000;
  localparam logic [USWC_PINS-1:0] USWC_RST_SUSP_LEVEL = 11'h000;
  localparam logic [USWC_PINS-1:0] USWC_RST_SUSP_OD = 11'h000;

  // Status register fields
  localparam int USWC_ST_SUSP_BIT = 0;
  localparam int USWC_ST_WAKE_BIT = 1;
  localparam int USWC_ST_INIT_BIT = 2;
  localparam int USWC_ST_PINS_LSB = 8;

  // Interrupt bits, same layout in status and mask
  localparam int USWC_IRQ_W = 4;
  localparam int USWC_IRQ_SUSP = 0;
  localparam int USWC_IRQ_EXIT = 1;
  localparam int USWC_IRQ_MISMATCH = 2;
  localparam int USWC_IRQ_BUSRST = 3;

  typedef enum logic [1:0] {
    USWC_INIT = 2'b00,
    USWC_ACTIVE = 2'b01,
    USWC_SUSP = 2'b11,
    USWC_WAKE = 2'b10
  } uswc_state_type;

  // Bus conditions reported by the USB core, one-cycle pulses
  typedef struct packed {
    logic suspend;
    logic resume;
    logic bus_reset;
    logic resume_sent;
  } uswc_usb_ev_type;

  typedef struct packed {
    logic [USWC_PINS-1:0] wake_sel;
    logic [USWC_PINS-1:0] wake_match;
    logic [USWC_PINS-1:0] susp_level;
    logic [USWC_PINS-1:0] susp_od;
  } uswc_cfg_type;

endpackage

// [logic/uswc_sync.sv]
// Purpose: Per-bit two-stage synchroniser for the general-purpose pin inputs
// Assumes: Inputs may change at any time relative to clk
// Notes: First stage feeds only the second stage
module uswc_sync
  import uswc_pkg::*;
#(
  parameter int WIDTH = USWC_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule

// [logic/uswc_pin_drive.sv]
// Purpose: Selects normal or suspend drive for each general-purpose pin
// Assumes: Output enable is active low
// Notes: Pins are released while reset is asserted
module uswc_pin_drive
  import uswc_pkg::*;
#(
  parameter int WIDTH = USWC_PINS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic suspended,
  input wire logic [WIDTH-1:0] susp_level,
  input wire logic [WIDTH-1:0] susp_od,
  // Normal-mode drive from the user side
  input wire logic [WIDTH-1:0] norm_out,
  input wire logic [WIDTH-1:0] norm_oe_n,
  // Pins
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe_n
);

  logic [WIDTH-1:0] next_out;
  logic [WIDTH-1:0] next_oe_n;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_comb begin
        if (suspended) begin
          // Open-drain only pulls low; a high level is left to the pull-up
          next_out[g] = susp_od[g] ? 1'b0 : susp_level[g];
          next_oe_n[g] = susp_od[g] & susp_level[g];
        end else begin
          next_out[g] = norm_out[g];
          next_oe_n[g] = norm_oe_n[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= next_out;
      pin_oe_n <= next_oe_n;
    end
  end

endmodule

// [logic/usb_suspend_wakeup_control.sv]
// Purpose: Tracks USB suspend/resume, drives the suspend indicator pair, raises remote wakeup
// Assumes: USB core reports bus conditions as one-cycle pulses on clk
// Notes: Indicators are released (oe_n high) while rst is asserted
// Notes on behaviour
// - Bus suspend enters the suspended state
// - Entering suspend asserts both indicators
// - Indicators asserted after reset until enumerated
// - Active-high indicator is one while suspended
// - Second indicator always inverse of first
// - Resume, bus reset, mismatch or reset leave suspend
// - Indicators released to weak pull during reset
// - Each pin individually selectable as wakeup source
// - Selected pin mismatch while suspended sends wakeup
// - Configured level and drive mode during suspend
//
// Added by the designer: the address-and-strobe port and the address map.
module usb_suspend_wakeup_control
  import uswc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // USB core
  input wire uswc_usb_ev_type usb_ev,
  input wire logic cfg_loaded,
  input wire logic enum_done,
  output logic remote_wakeup_req,
  // Register port
  input wire logic [USWC_ADDR_W-1:0] reg_addr,
  input wire logic [USWC_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [USWC_DATA_W-1:0] reg_rdata,
  output logic irq,
  // Suspend indicator pins
  output logic susp_hi_out,
  output logic susp_hi_oe_n,
  output logic susp_lo_out,
  output logic susp_lo_oe_n,
  // General-purpose pins
  input wire logic [USWC_PINS-1:0] gpio_in,
  output logic [USWC_PINS-1:0] gpio_out,
  output logic [USWC_PINS-1:0] gpio_oe_n,
  // Normal-mode pin drive from the user side
  input wire logic [USWC_PINS-1:0] gpio_norm_out,
  input wire logic [USWC_PINS-1:0] gpio_norm_oe_n
);

  uswc_state_type state;
  uswc_state_type next_state;
  uswc_cfg_type cfg;
  uswc_cfg_type next_cfg;
  logic [USWC_IRQ_W-1:0] irq_stat;
  logic [USWC_IRQ_W-1:0] next_irq_stat;
  logic [USWC_IRQ_W-1:0] irq_mask;
  logic [USWC_IRQ_W-1:0] next_irq_mask;
  logic [USWC_IRQ_W-1:0] irq_set;
  logic [USWC_DATA_W-1:0] next_rdata;
  logic next_susp;
  logic susp_ind;
  logic ind_oe_n;
  logic next_wake_req;
  logic [USWC_PINS-1:0] gpio_sync;
  logic mismatch;
  logic resume_any;

  // Pin inputs crossed into clk before any comparison
  uswc_sync #(
    .WIDTH(USWC_PINS)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din(gpio_in),
    .dout(gpio_sync)
  );

  // Mismatch on any selected pin; evaluated only in the suspended state
  assign mismatch = (state == USWC_SUSP) & (|((gpio_sync ^ cfg.wake_match) & cfg.wake_sel));
  assign resume_any = usb_ev.resume | usb_ev.resume_sent;

  // State sequencing
  always_comb begin
    next_state = state;
    next_wake_req = 1'b0;
    unique case (state)
      USWC_INIT: begin
        // Held here until configuration and enumeration both finish
        if (cfg_loaded & enum_done) begin
          next_state = USWC_ACTIVE;
        end
      end
      USWC_ACTIVE: begin
        if (usb_ev.suspend) begin
          next_state = USWC_SUSP;
        end
      end
      USWC_SUSP: begin
        if (usb_ev.bus_reset | resume_any) begin
          next_state = USWC_ACTIVE;
        end else if (mismatch) begin
          next_state = USWC_WAKE;
          next_wake_req = 1'b1;
        end
      end
      USWC_WAKE: begin
        // Wakeup signalling held until the host resumes or resets the bus, or a device-sent resume is reported
        if (usb_ev.bus_reset | resume_any) begin
          next_state = USWC_ACTIVE;
        end else begin
          next_wake_req = 1'b1;
        end
      end
    endcase
  end

  // Indicator level follows the next state so it changes with the state itself
  always_comb begin
    next_susp = (next_state == USWC_SUSP) | (next_state == USWC_INIT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= USWC_INIT;
      susp_ind <= 1'b1;
      ind_oe_n <= 1'b1;
      remote_wakeup_req <= 1'b0;
    end else begin
      state <= next_state;
      susp_ind <= next_susp;
      ind_oe_n <= 1'b0;
      remote_wakeup_req <= next_wake_req;
    end
  end

  // Released pins still carry their logic value; the board pull decides the wire
  assign susp_hi_out = susp_ind;
  assign susp_lo_out = ~susp_ind;
  assign susp_hi_oe_n = ind_oe_n;
  assign susp_lo_oe_n = ind_oe_n;

  // Suspend-time pin drive
  uswc_pin_drive #(
    .WIDTH(USWC_PINS)
  ) u_pins (
    .clk(clk),
    .rst(rst),
    .suspended(state == USWC_SUSP),
    .susp_level(cfg.susp_level),
    .susp_od(cfg.susp_od),
    .norm_out(gpio_norm_out),
    .norm_oe_n(gpio_norm_oe_n),
    .pin_out(gpio_out),
    .pin_oe_n(gpio_oe_n)
  );

  // Interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[USWC_IRQ_SUSP] = (state != USWC_SUSP) & (next_state == USWC_SUSP);
    irq_set[USWC_IRQ_EXIT] = (state == USWC_SUSP) & (next_state != USWC_SUSP);
    irq_set[USWC_IRQ_MISMATCH] = mismatch;
    irq_set[USWC_IRQ_BUSRST] = usb_ev.bus_reset;
  end

  // Register writes
  always_comb begin
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (reg_wr) begin
      unique case (reg_addr)
        USWC_OFS_WAKE_SEL: next_cfg.wake_sel = reg_wdata[USWC_PINS-1:0];
        USWC_OFS_WAKE_MATCH: next_cfg.wake_match = reg_wdata[USWC_PINS-1:0];
        USWC_OFS_SUSP_LEVEL: next_cfg.susp_level = reg_wdata[USWC_PINS-1:0];
        USWC_OFS_SUSP_OD: next_cfg.susp_od = reg_wdata[USWC_PINS-1:0];
        USWC_OFS_IRQ_MASK: next_irq_mask = reg_wdata[USWC_IRQ_W-1:0];
        USWC_OFS_IRQ_STAT: next_irq_stat = irq_stat & ~reg_wdata[USWC_IRQ_W-1:0];
        default: ;
      endcase
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | irq_set;
  end

  // Register reads; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        USWC_OFS_WAKE_SEL: next_rdata[USWC_PINS-1:0] = cfg.wake_sel;
        USWC_OFS_WAKE_MATCH: next_rdata[USWC_PINS-1:0] = cfg.wake_match;
        USWC_OFS_SUSP_LEVEL: next_rdata[USWC_PINS-1:0] = cfg.susp_level;
        USWC_OFS_SUSP_OD: next_rdata[USWC_PINS-1:0] = cfg.susp_od;
        USWC_OFS_STATUS: begin
          next_rdata[USWC_ST_SUSP_BIT] = (state == USWC_SUSP);
          next_rdata[USWC_ST_WAKE_BIT] = (state == USWC_WAKE);
          next_rdata[USWC_ST_INIT_BIT] = (state == USWC_INIT);
          next_rdata[USWC_ST_PINS_LSB +: USWC_PINS] = gpio_sync;
        end
        USWC_OFS_IRQ_STAT: next_rdata[USWC_IRQ_W-1:0] = irq_stat;
        USWC_OFS_IRQ_MASK: next_rdata[USWC_IRQ_W-1:0] = irq_mask;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg.wake_sel <= USWC_RST_WAKE_SEL;
      cfg.wake_match <= USWC_RST_WAKE_MATCH;
      cfg.susp_level <= USWC_RST_SUSP_LEVEL;
      cfg.susp_od <= USWC_RST_SUSP_OD;
      irq_stat <= '0;
      irq_mask <= '0;
      reg_rdata <= '0;
    end else begin
      cfg <= next_cfg;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      reg_rdata <= next_rdata;
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule

// [tb/uswc_props.sv]
// Purpose: Concurrent checks on the suspend indicator and wakeup ports
// Assumes: One clock domain, rst asynchronous and active high
// Notes: Bound to the design top from the bench top file
module uswc_props
  import uswc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // USB core
  input wire uswc_usb_ev_type usb_ev,
  input wire logic cfg_loaded,
  input wire logic enum_done,
  input wire logic remote_wakeup_req,
  // Indicators
  input wire logic susp_hi_out,
  input wire logic susp_lo_out,
  input wire logic susp_hi_oe_n,
  input wire logic susp_lo_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic exit_ev = usb_ev.resume | usb_ev.bus_reset | usb_ev.resume_sent;

  a_lo_inverse: assert property (susp_lo_out == !susp_hi_out)
    else $error("low indicator not inverse");
  // Reset itself is the cause here, so no disable
  a_oe_release: assert property (disable iff (1'b0) rst |-> susp_hi_oe_n && susp_lo_oe_n)
    else $error("indicators driven in reset");
  a_oe_driven: assert property (!$past(rst) |-> !susp_hi_oe_n && !susp_lo_oe_n)
    else $error("indicators released after reset");
  a_init_hold: assert property ($fell(rst) |-> susp_hi_out [*6])
    else $error("indicator dropped before enumeration");
  a_enum_exit: assert property ($rose(cfg_loaded && enum_done) |=> !susp_hi_out)
    else $error("indicator held after enumeration");
  a_susp_enter: assert property (usb_ev.suspend && !susp_hi_out && !remote_wakeup_req |=> susp_hi_out)
    else $error("suspend not entered");
  a_resume_exit: assert property (exit_ev && cfg_loaded && enum_done |=> !susp_hi_out)
    else $error("suspend not left");
  a_wake_rise: assert property ($rose(remote_wakeup_req) |-> $past(susp_hi_out) && !susp_hi_out)
    else $error("wakeup outside suspend");
  a_wake_clear: assert property (remote_wakeup_req && exit_ev |=> !remote_wakeup_req)
    else $error("wakeup request kept after resume");
endmodule

// [tb/uswc_host_model.sv]
// Purpose: Behavioural USB host facing the suspend/wakeup block
// Assumes: Bus conditions are one-cycle pulses on clk
// Notes: Answers remote wakeup only when wake_en is set
module uswc_host_model
  import uswc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Device side
  input wire logic remote_wakeup_req,
  output uswc_usb_ev_type usb_ev,
  // Behaviour
  input wire logic wake_en,
  input wire logic [3:0] reply_dly
);
  timeunit 1ns;
  timeprecision 100ps;
  initial usb_ev = '0;
  task automatic send(input logic [3:0] ev);
    @(posedge clk);
    usb_ev <= ev;
    @(posedge clk);
    usb_ev <= '0;
  endtask
  // A slow host simply waits longer before resuming
  always @(posedge clk) begin
    if (remote_wakeup_req && wake_en) begin
      repeat (reply_dly) @(posedge clk);
      usb_ev <= 4'h4;
      @(posedge clk);
      usb_ev <= '0;
    end
  end
endmodule

// [tb/tb_usb_suspend_wakeup_control.sv]
// Purpose: Directed bench for the USB suspend/wakeup block
// Assumes: 40 MHz clock, host model answers wakeup after 5 cycles
// Notes: Normal-mode pin drive is held at fixed patterns by the stimulus
module tb_usb_suspend_wakeup_control
  import uswc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, cfg_loaded, enum_done, reg_wr, reg_rd, irq, remote_wakeup_req;
  logic susp_hi_out, susp_lo_out, susp_hi_oe_n, susp_lo_oe_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [USWC_PINS-1:0] gpio_in, gpio_out, gpio_oe_n;
  logic [USWC_PINS-1:0] gpio_norm_out, gpio_norm_oe_n;
  uswc_usb_ev_type usb_ev;
  int miscompares, checks_done;

  usb_suspend_wakeup_control i_dut (.clk, .rst, .usb_ev, .cfg_loaded, .enum_done, .remote_wakeup_req,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .susp_hi_out, .susp_hi_oe_n,
    .susp_lo_out, .susp_lo_oe_n, .gpio_in, .gpio_out, .gpio_oe_n,
    .gpio_norm_out, .gpio_norm_oe_n);
  uswc_host_model i_host (.clk, .remote_wakeup_req, .usb_ev, .wake_en(1'b1), .reply_dly(4'h5));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata, e);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic ind(input logic [3:0] e);
    chk(32'({susp_hi_out, susp_lo_out, susp_hi_oe_n, susp_lo_oe_n}), 32'(e));
  endtask

  initial begin
    #50us;
    miscompares++;
    conclude();
  end

  initial begin
    {rst, cfg_loaded, enum_done, reg_wr, reg_rd} = 5'b10000;
    reg_addr = '0;
    reg_wdata = '0;
    gpio_in = '0;
    gpio_norm_out = 11'h5A5;
    gpio_norm_oe_n = 11'h0F0;
    miscompares = 0;
    checks_done = 0;
    @(negedge clk);
    ind(4'hB);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wt(8);
    ind(4'h8);
    // Reset values, unmapped 0x1C included; status skipped in init
    for (int a = 0; a < 8; a++)
      if (a != 4) rd(8'(4 * a), 32'h0);
    @(posedge clk);
    {cfg_loaded, enum_done} <= 2'b11;
    wt(3);
    ind(4'h4);
    chk(32'({gpio_out, gpio_oe_n}), 32'({11'h5A5, 11'h0F0}));
    wr(8'h00, 32'h400);
    wr(8'h08, 32'h0F3);
    wr(8'h0C, 32'h00F);
    wr(8'h18, 32'hF);
    i_host.send(4'h8);
    wt(2);
    ind(4'h8);
    chk(32'(irq), 32'h1);
    // Push-pull pins drive the level, open-drain ones only pull low
    chk(32'({gpio_out, gpio_oe_n}), 32'({11'h0F0, 11'h003}));
    rd(8'h10, 32'h1);
    wr(8'h14, 32'h1);
    wt(1);
    chk(32'(irq), 32'h0);
    @(posedge clk);
    gpio_in <= 11'h001;
    wt(8);
    chk(32'(susp_hi_out), 32'h1);
    @(posedge clk);
    gpio_in <= 11'h401;
    for (int i = 0; i < 8 && remote_wakeup_req !== 1'b1; i++)
      @(negedge clk);
    chk(32'({remote_wakeup_req, susp_hi_out}), 32'h2);
    wt(8);
    chk(32'(remote_wakeup_req), 32'h0);
    rd(8'h14, 32'h6);
    @(posedge clk);
    gpio_in <= '0;
    wr(8'h14, 32'hF);
    // Each exit event: resume, bus reset, device-sent resume
    for (int k = 0; k < 3; k++) begin
      i_host.send(4'h8);
      wt(2);
      chk(32'(susp_hi_out), 32'h1);
      i_host.send(4'h4 >> k);
      wt(2);
      chk(32'(susp_hi_out), 32'h0);
    end
    rd(8'h14, 32'hB);
    i_host.send(4'h8);
    wt(2);
    @(posedge clk);
    {rst, cfg_loaded, enum_done} <= 3'b100;
    @(negedge clk);
    ind(4'hB);
    chk(32'(gpio_oe_n), 32'h7FF);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wt(8);
    ind(4'h8);
    conclude();
  end
endmodule

bind usb_suspend_wakeup_control uswc_props i_props (.clk, .rst, .usb_ev, .cfg_loaded, .enum_done,
  .remote_wakeup_req, .susp_hi_out, .susp_lo_out, .susp_hi_oe_n, .susp_lo_oe_n);
